// *** rtl/csb_cond_eval.sv ***
`timescale 1ns/1ps
// flag test for the set-byte group; pure combinational
module csb_cond_eval
  import csb_pkg::*;
(
  // condition select and flags
  input wire logic [3:0] cond,
  input wire logic flag_of,
  input wire logic flag_sf,
  input wire logic flag_zf,
  input wire logic flag_pf,
  input wire logic flag_cf,
  // outcome
  output logic holds,
  output logic known
);
  // low bit of the code inverts the base test
  always_comb begin
    holds = 1'b0;
    known = 1'b1;
    unique case (cond)
      COND_OVERFLOW: holds = flag_of;
      COND_NO_OVERFLOW: holds = !flag_of;
      COND_UNEQUAL: holds = !flag_zf;
      COND_ABOVE: holds = !(flag_cf || flag_zf);
      COND_POSITIVE: holds = !flag_sf;
      COND_EVEN_PARITY: holds = flag_pf;
      COND_ODD_PARITY: holds = !flag_pf;
      COND_GREATER_EQUAL: holds = (flag_sf == flag_of);
      COND_GREATER: holds = !flag_zf && (flag_sf == flag_of);
      default: known = 1'b0; // other codes belong to other blocks
    endcase
  end
endmodule

// *** rtl/csb_decode.sv ***
`timescale 1ns/1ps
// What this block does
// - 0F 97 reg 000 sets if above, 2 clocks
// - 0F 95 reg 000 sets if not equal
// - 0F 9D reg 000 sets if greater or equal
// - 0F 9F reg 000 sets if greater
// - 0F 91 reg 000 no overflow, 2 clocks
// - 0F 9B reg 000 sets if parity odd
// - 0F 99 reg 000 sets if not sign
// - 0F 90 reg 000 sets if overflow
// - 0F 9A reg 000 parity even, mode-independent timing
module csb_decode
  import csb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fetch stream, one byte per valid cycle
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  // flags from the core
  input wire logic flag_of,
  input wire logic flag_sf,
  input wire logic flag_zf,
  input wire logic flag_pf,
  input wire logic flag_cf,
  // operating mode, timing does not depend on it
  input wire logic protected_mode,
  // result write to register file or cache
  output logic wr_valid,
  output logic wr_to_reg,
  output logic [2:0] wr_rm,
  output logic [1:0] wr_mod,
  output logic [7:0] wr_data,
  // flag write enable, always low for this group
  output logic flags_we,
  // second or third byte was not one of ours
  output logic not_ours
);
  // ************************************************************
  // sequencing
  // ************************************************************
  csb_state_t state;
  logic [3:0] cond;
  logic [1:0] mod_f;
  logic [2:0] rm_f;
  logic holds;
  logic known;
  logic [1:0] exec_cnt;
  logic next_not_ours;

  function automatic logic is_set_opcode(input logic [7:0] b);
    is_set_opcode = (b[7:4] == SET_GROUP);
  endfunction

  csb_cond_eval u_eval (
    .cond(cond),
    .flag_of(flag_of),
    .flag_sf(flag_sf),
    .flag_zf(flag_zf),
    .flag_pf(flag_pf),
    .flag_cf(flag_cf),
    .holds(holds),
    .known(known)
  );

  // fetch is stalled while the write is pending
  assign byte_ready = (state != csb_exec);
  assign flags_we = 1'b0;

  // next-state logic; protected_mode deliberately not consulted
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= csb_idle;
    end else begin
      unique case (state)
        csb_idle: begin
          if (byte_valid && byte_data == ESCAPE_BYTE) begin
            state <= csb_escape;
          end
        end
        csb_escape: begin
          if (byte_valid) begin
            state <= is_set_opcode(byte_data) ? csb_modrm : csb_idle;
          end
        end
        csb_modrm: begin
          if (byte_valid) begin
            // reg field must be zero, else hand back
            if (byte_data[5:3] == REG_FIELD_SET && known) begin
              state <= csb_exec;
            end else begin
              state <= csb_idle;
            end
          end
        end
        csb_exec: begin
          if (exec_cnt == 2'(EXEC_CLOCKS - 1)) begin
            state <= csb_idle;
          end
        end
      endcase
    end
  end

  // latched operand fields
  always_ff @(posedge clk) begin
    if (rst) begin
      cond <= 4'h0;
      mod_f <= 2'h0;
      rm_f <= 3'h0;
    end else begin
      if (state == csb_escape && byte_valid) begin
        cond <= byte_data[3:0];
      end
      if (state == csb_modrm && byte_valid) begin
        mod_f <= byte_data[7:6];
        rm_f <= byte_data[2:0];
      end
    end
  end

  // execution clock counter; one count per cycle of the write phase
  always_ff @(posedge clk) begin
    if (rst) begin
      exec_cnt <= 2'h0;
    end else if (state == csb_exec) begin
      exec_cnt <= exec_cnt + 2'h1;
    end else begin
      exec_cnt <= 2'h0;
    end
  end

  // result byte written in the last execution clock
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_valid <= 1'b0;
      wr_to_reg <= 1'b0;
      wr_rm <= 3'h0;
      wr_mod <= 2'h0;
      wr_data <= 8'h00;
    end else begin
      wr_valid <= (state == csb_exec) && (exec_cnt == 2'(EXEC_CLOCKS - 2));
      // flags sampled once only, so the result byte stands until the next instruction
      if (state == csb_exec && exec_cnt == 2'(EXEC_CLOCKS - 2)) begin
        wr_to_reg <= (mod_f == MOD_REGISTER);
        wr_rm <= rm_f;
        wr_mod <= mod_f;
        wr_data <= holds ? RESULT_TRUE : RESULT_FALSE;
      end
    end
  end

  // report a rejected second or third byte
  always_comb begin
    next_not_ours = 1'b0;
    if (state == csb_escape && byte_valid && !is_set_opcode(byte_data)) begin
      next_not_ours = 1'b1;
    end
    if (state == csb_modrm && byte_valid && (byte_data[5:3] != REG_FIELD_SET || !known)) begin
      next_not_ours = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      not_ours <= 1'b0;
    end else begin
      not_ours <= next_not_ours;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_exec_len;
    @(posedge clk) disable iff (rst)
      $rose(state == csb_exec) |-> (state == csb_exec) [*2] ##1 (state != csb_exec);
  endproperty
  a_exec_len: assert property (p_exec_len) else $error("exec not two clocks");

  property p_one_write;
    @(posedge clk) disable iff (rst)
      $rose(state == csb_exec) |-> ##1 wr_valid ##1 !wr_valid;
  endproperty
  a_one_write: assert property (p_one_write) else $error("write not once");

  property p_bool_data;
    @(posedge clk) disable iff (rst)
      wr_valid |-> (wr_data == RESULT_TRUE || wr_data == RESULT_FALSE);
  endproperty
  a_bool_data: assert property (p_bool_data) else $error("result not 0 or 1");

  property p_no_flags;
    @(posedge clk) disable iff (rst) !flags_we;
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("flags written");

  property p_reg_zero;
    @(posedge clk) disable iff (rst)
      (state == csb_modrm && byte_valid && byte_data[5:3] != REG_FIELD_SET)
      |=> state == csb_idle && not_ours;
  endproperty
  a_reg_zero: assert property (p_reg_zero) else $error("nonzero reg accepted");

  property p_above;
    @(posedge clk) disable iff (rst)
      (state == csb_exec && cond == COND_ABOVE && exec_cnt == 2'h0)
      |=> wr_data == ((!$past(flag_cf) && !$past(flag_zf)) ? RESULT_TRUE : RESULT_FALSE);
  endproperty
  a_above: assert property (p_above) else $error("above result wrong");

  property p_greater;
    @(posedge clk) disable iff (rst)
      (state == csb_exec && cond == COND_GREATER && exec_cnt == 2'h0)
      |=> wr_data[0] == (!$past(flag_zf) && ($past(flag_sf) == $past(flag_of)));
  endproperty
  a_greater: assert property (p_greater) else $error("greater result wrong");

  property p_parity;
    @(posedge clk) disable iff (rst)
      (state == csb_exec && cond == COND_EVEN_PARITY && exec_cnt == 2'h0)
      |=> wr_data[0] == $past(flag_pf);
  endproperty
  a_parity: assert property (p_parity) else $error("parity result wrong");

  property p_stall;
    @(posedge clk) disable iff (rst) (state == csb_exec) |-> !byte_ready;
  endproperty
  a_stall: assert property (p_stall) else $error("fetch not stalled");

  c_reg_write: cover property (@(posedge clk) disable iff (rst) wr_valid && wr_to_reg);
  c_mem_write: cover property (@(posedge clk) disable iff (rst) wr_valid && !wr_to_reg);
  c_true: cover property (@(posedge clk) disable iff (rst) wr_valid && wr_data[0]);
  c_reject: cover property (@(posedge clk) disable iff (rst) not_ours);
endmodule

// *** rtl/csb_pkg.sv ***
package csb_pkg;
  // ************************************************************
  // opcode encoding
  // ************************************************************
  localparam logic [7:0] ESCAPE_BYTE = 8'h0f;
  localparam logic [3:0] SET_GROUP = 4'h9; // upper nibble of the second byte
  localparam logic [2:0] REG_FIELD_SET = 3'h0;
  localparam logic [3:0] COND_OVERFLOW = 4'h0;
  localparam logic [3:0] COND_NO_OVERFLOW = 4'h1;
  localparam logic [3:0] COND_UNEQUAL = 4'h5;
  localparam logic [3:0] COND_ABOVE = 4'h7;
  localparam logic [3:0] COND_POSITIVE = 4'h9;
  localparam logic [3:0] COND_EVEN_PARITY = 4'ha;
  localparam logic [3:0] COND_ODD_PARITY = 4'hb;
  localparam logic [3:0] COND_GREATER_EQUAL = 4'hd;
  localparam logic [3:0] COND_GREATER = 4'hf;
  localparam logic [1:0] MOD_REGISTER = 2'h3;
  // ************************************************************
  // timing: both clocks of the 2/2 figure and the 2 on a miss
  // ************************************************************
  localparam int unsigned EXEC_CLOCKS = 2;
  localparam logic [7:0] RESULT_TRUE = 8'h01;
  localparam logic [7:0] RESULT_FALSE = 8'h00;
  typedef enum logic [1:0] {
    csb_idle,
    csb_escape,
    csb_modrm,
    csb_exec
  } csb_state_t;
endpackage

// *** tb/conditional_set_byte_decode_tb_top.sv ***
`timescale 1ns/1ps
module conditional_set_byte_decode_tb_top;
  import csb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic byte_valid, byte_ready, wr_valid, wr_to_reg, flags_we, not_ours;
  logic [7:0] byte_data, wr_data;
  logic [2:0] wr_rm;
  logic [1:0] wr_mod;
  logic [4:0] fl = 5'h00; // of sf zf pf cf
  logic pm = 1'b0;
  int mismatches = 0;
  int tests_run = 0;
  // ****
  // clock, design and partner
  // ****
  always #12.5 clk = ~clk;
  csb_decode dut_u (.clk(clk), .rst(rst), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(byte_ready), .flag_of(fl[4]), .flag_sf(fl[3]), .flag_zf(fl[2]),
    .flag_pf(fl[1]), .flag_cf(fl[0]), .protected_mode(pm), .wr_valid(wr_valid),
    .wr_to_reg(wr_to_reg), .wr_rm(wr_rm), .wr_mod(wr_mod), .wr_data(wr_data),
    .flags_we(flags_we), .not_ours(not_ours));
  csb_fetch_model fm (.clk(clk), .rst(rst), .byte_ready(byte_ready),
    .byte_valid(byte_valid), .byte_data(byte_data));
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    tests_run++;
    if (a !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  // one full instruction; the write must land in the second stalled cycle
  task automatic op(input logic [7:0] opc, input logic [7:0] mrm, input logic [4:0] f,
    input logic e);
    int n;
    @(posedge clk) fl <= f;
    @(negedge clk);
    fm.push(ESCAPE_BYTE);
    fm.push(opc);
    fm.push(mrm);
    n = 0;
    while (byte_ready !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk(wr_valid, 8'h00);
    @(negedge clk);
    chk({wr_valid, byte_ready, flags_we, not_ours}, 8'h08);
    chk(wr_data, e ? RESULT_TRUE : RESULT_FALSE);
    chk({wr_to_reg, wr_mod, wr_rm}, {mrm[7:6] == 2'h3, mrm[7:6], mrm[2:0]});
    @(negedge clk);
    chk({wr_valid, byte_ready}, 8'h01);
  endtask
  // rejected byte: a single not_ours pulse and no write
  task automatic rej(input logic [7:0] b2, input logic [7:0] b3, input logic three);
    int n;
    @(negedge clk);
    fm.push(ESCAPE_BYTE);
    fm.push(b2);
    if (three) fm.push(b3);
    n = 0;
    while (not_ours !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk({not_ours, wr_valid}, 8'h02);
    @(negedge clk);
    chk(not_ours, 8'h00);
  endtask
  task automatic t_unsigned;
    for (int i = 0; i < 4; i++) begin
      op(8'h97, 8'hc5, {2'h0, i[1], 1'b0, i[0]}, i == 0);
      op(8'h95, 8'h06, {2'h0, i[0], 2'h0}, !i[0]);
    end
    $display("done unsigned");
  endtask
  task automatic t_signed;
    for (int i = 0; i < 8; i++) begin
      op(8'h9d, 8'hc1, {i[2:0], 2'h0}, i[2] == i[1]);
      op(8'h9f, 8'h03, {i[2:0], 2'h0}, i[2] == i[1] && !i[0]);
      op(8'h99, 8'hc7, {1'b0, i[1], 3'h0}, !i[1]);
    end
    $display("done signed");
  endtask
  task automatic t_flags_mode;
    fm.slow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) pm <= i[1];
      op(8'h90, 8'hc2, {i[0], 4'h0}, i[0]);
      op(8'h91, 8'h45, {i[0], 4'h0}, !i[0]);
      op(8'h9a, 8'hc3, {3'h0, i[0], 1'b0}, i[0]);
      op(8'h9b, 8'h87, {3'h0, i[0], 1'b0}, !i[0]);
    end
    fm.slow = 1'b0;
    $display("done flags and mode");
  endtask
  task automatic t_reject;
    // a 9x code outside the group is only refused when its modrm byte arrives
    rej(8'h92, 8'h00, 1'b1);
    rej(8'h97, 8'hc8, 1'b1);
    rej(8'h21, 8'h00, 1'b0);
    op(8'h97, 8'hc0, 5'h00, 1'b1);
    $display("done reject");
  endtask
  task automatic summarize;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****
  // main sequence and watchdog
  // ****
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_unsigned();
    t_signed();
    t_flags_mode();
    t_reject();
    summarize();
  end
  initial begin
    #(25 * 5000);
    mismatches++;
    summarize();
  end
endmodule

// *** tb/csb_fetch_model.sv ***
`timescale 1ns/1ps
// ****
// fetch stage model
// ****
module csb_fetch_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // byte stream
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] q[$];
  logic slow = 1'b0;
  logic skip;
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h5a;
  end
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // hold each byte until taken; idle data toggles so a stale byte never looks valid
  always @(posedge clk) begin
    skip = 1'b0;
    if (rst) begin
      byte_valid <= 1'b0;
    end else begin
      if (byte_valid && byte_ready) begin
        q.delete(0);
        skip = slow; // slow mode leaves a gap
      end
      if (q.size() > 0 && !skip) begin
        byte_valid <= 1'b1;
        byte_data <= q[0];
      end else begin
        byte_valid <= 1'b0;
        byte_data <= ~byte_data;
      end
    end
  end
endmodule
